// *** hdl/prof_pkg.sv ***
// Constants for the profiling control block and its ring of records.
// Assumes byte offsets within the block and 32-bit software word access.
package prof_pkg;
	localparam logic [6:0] OFF_FLAGS = 7'h00;
	localparam logic [6:0] OFF_SIZE = 7'h04;
	localparam logic [6:0] OFF_BASE_LO = 7'h08;
	localparam logic [6:0] OFF_BASE_HI = 7'h0c;
	localparam logic [6:0] OFF_HEAD = 7'h10;
	localparam logic [6:0] OFF_DROP_LO = 7'h18;
	localparam logic [6:0] OFF_DROP_HI = 7'h1c;
	localparam logic [6:0] OFF_THR = 7'h20;
	localparam logic [6:0] OFF_FILT = 7'h24;
	localparam logic [6:0] OFF_IPLO_LO = 7'h28;
	localparam logic [6:0] OFF_IPLO_HI = 7'h2c;
	localparam logic [6:0] OFF_IPHI_LO = 7'h30;
	localparam logic [6:0] OFF_IPHI_HI = 7'h34;
	localparam logic [6:0] OFF_TAIL = 7'h40;
	localparam int SIZE_MSB = 27;
	localparam int RAND_LSB = 28;
	localparam int RAND_W = 4;
	localparam int REC_SHIFT = 5;
	localparam logic [31:0] REC_BYTES = 32'h0000_0020;
	localparam int THR_EN_BIT = 31;
	localparam int INTERVAL_W = 25;
	localparam int FIFO_DEPTH = 8;
	localparam int DATA_W = 32;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// *** hdl/rec_fifo.sv ***
// Record FIFO between the event source and the ring writer.
// Assumes one clock; read data comes straight from the storage registers.
`timescale 1ns/10ps
module rec_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (cnt_q < (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** hdl/rand_reload.sv ***
// Counter reload with randomised low bits from a free-running LFSR.
// Assumes reload requests are single-cycle pulses.
`timescale 1ns/10ps
module rand_reload (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reload_req,
	input wire logic [prof_pkg::INTERVAL_W-1:0] interval,
	input wire logic [prof_pkg::RAND_W-1:0] rand_bits,
	output logic [prof_pkg::INTERVAL_W-1:0] reload_value,
	output logic reload_done
);
	logic [15:0] lfsr_q;
	wire [prof_pkg::INTERVAL_W-1:0] mask =
		prof_pkg::INTERVAL_W'((32'h1 << rand_bits) - 32'h1);
	wire [prof_pkg::INTERVAL_W-1:0] noise =
		{{(prof_pkg::INTERVAL_W-16){1'b0}}, lfsr_q};
	wire fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lfsr_q <= prof_pkg::LFSR_SEED;
			reload_value <= '0;
			reload_done <= 1'b0;
		end else begin
			lfsr_q <= {lfsr_q[14:0], fb};
			reload_done <= reload_req;
			if (reload_req) begin
				// Low bits replaced by noise
				reload_value <= (interval & ~mask) | (noise & mask);
			end
		end
	end

	rnd_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
		reload_req |=> ((reload_value & ~$past(mask)) ==
		($past(interval) & ~$past(mask))) && reload_done)
		else $error("reload kept bits above random field wrong");
endmodule

// *** hdl/prof_ring_ctrl.sv ***
// Profiling control block and ring-buffer writer.
// Assumes software reaches the block through a 32-bit word port and the
// ring writes go to a memory that may stall through mem_wr_ready.
//
// Overview of operation
// - Block load ANDs requested flags with capability bits and stores it.
// - Ring size is bits 27:0 of word 4, rounded down to records.
// - Counter reloads replace the configured number of low bits by noise.
// - Block load keeps the linear ring base; the base field stays intact.
// - Each record goes to ring base plus head offset.
// - Ring is empty whenever head equals tail.
// - A head not below ring size is replaced by zero.
// - A head not on a record boundary is rounded down.
// - Advance hitting tail leaves head and bumps the dropped counter.
// - While full, each new record overwrites the last slot.
// - Dropped counter is updated only by the device; head also by software while profiling is off.
// - Init fields are rewritten during block load; flags also by software while profiling is off.
// - The device never writes the tail offset.
// - After an advance, used space at or over threshold raises interrupt.
// - Constant fields are loaded when profiling is enabled.
`timescale 1ns/10ps
module prof_ring_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sw_wr,
	input wire logic sw_rd,
	input wire logic [6:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	output logic [31:0] sw_rdata,
	input wire logic load_req,
	input wire logic disable_req,
	input wire logic [31:0] cap_bits,
	input wire logic [63:0] seg_base,
	output logic active,
	input wire logic rec_valid,
	output logic rec_ready,
	input wire logic [31:0] rec_data,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [63:0] mem_wr_addr,
	output logic [31:0] mem_wr_data,
	input wire logic reload_req,
	input wire logic [prof_pkg::INTERVAL_W-1:0] reload_interval,
	output logic [prof_pkg::INTERVAL_W-1:0] reload_value,
	output logic reload_done,
	output logic ring_empty,
	output logic thr_irq
);
	////////////////////////////////////////////////////////////////////////
	// Control block fields
	logic [31:0] flags_q;
	logic [31:0] size_q;
	logic [63:0] base_q;
	logic [63:0] lin_base_q;
	logic [31:0] head_q;
	logic [63:0] drop_q;
	logic [31:0] thr_q;
	logic [31:0] filt_q;
	logic [63:0] iplo_q;
	logic [63:0] iphi_q;
	logic [31:0] tail_q;
	logic active_q;
	logic irq_q;
	logic [31:0] rdata_q;

	wire wr_flags = sw_wr && sw_addr == prof_pkg::OFF_FLAGS && !active_q;
	wire wr_size = sw_wr && sw_addr == prof_pkg::OFF_SIZE;
	wire wr_base_lo = sw_wr && sw_addr == prof_pkg::OFF_BASE_LO;
	wire wr_base_hi = sw_wr && sw_addr == prof_pkg::OFF_BASE_HI;
	wire wr_head = sw_wr && sw_addr == prof_pkg::OFF_HEAD && !active_q;
	wire wr_thr = sw_wr && sw_addr == prof_pkg::OFF_THR;
	wire wr_filt = sw_wr && sw_addr == prof_pkg::OFF_FILT;
	wire wr_iplo_lo = sw_wr && sw_addr == prof_pkg::OFF_IPLO_LO;
	wire wr_iplo_hi = sw_wr && sw_addr == prof_pkg::OFF_IPLO_HI;
	wire wr_iphi_lo = sw_wr && sw_addr == prof_pkg::OFF_IPHI_LO;
	wire wr_iphi_hi = sw_wr && sw_addr == prof_pkg::OFF_IPHI_HI;
	wire wr_tail = sw_wr && sw_addr == prof_pkg::OFF_TAIL;

	////////////////////////////////////////////////////////////////////////
	// Ring arithmetic
	// Effective size: low 28 bits, record aligned
	wire [31:0] size_raw = {4'h0, size_q[prof_pkg::SIZE_MSB:0]};
	wire [31:0] size_eff = size_raw &
		~((32'h1 << prof_pkg::REC_SHIFT) - 32'h1);
	wire [31:0] rec_mask = ~((32'h1 << prof_pkg::REC_SHIFT) - 32'h1);
	// Head sanitised at load
	wire [31:0] head_san = (head_q >= size_eff) ? 32'h0 : (head_q & rec_mask);
	wire [31:0] thr_eff = thr_q & rec_mask;
	wire [31:0] next_raw = head_q + prof_pkg::REC_BYTES;
	wire [31:0] next_head = (next_raw >= size_eff) ? 32'h0 : next_raw;
	wire ring_full = (next_head == tail_q);
	wire store = mem_wr_valid && mem_wr_ready;
	wire [31:0] used = (next_head >= tail_q) ? next_head - tail_q :
		next_head + size_eff - tail_q;
	wire thr_hit = store && !ring_full && flags_q[prof_pkg::THR_EN_BIT] &&
		used >= thr_eff;
	wire [63:0] lin_load = base_q + seg_base;
	wire [31:0] flags_masked = flags_q & cap_bits;
	wire fifo_out_valid;
	wire fifo_out_ready = active_q && mem_wr_ready;

	assign active = active_q;
	assign ring_empty = (head_q == tail_q);
	assign mem_wr_valid = fifo_out_valid && active_q;
	assign mem_wr_addr = lin_base_q + {32'h0, head_q};
	assign thr_irq = irq_q;
	assign sw_rdata = rdata_q;

	wire [31:0] rd_mux =
		(sw_addr == prof_pkg::OFF_FLAGS) ? flags_q :
		(sw_addr == prof_pkg::OFF_SIZE) ? size_q :
		(sw_addr == prof_pkg::OFF_BASE_LO) ? base_q[31:0] :
		(sw_addr == prof_pkg::OFF_BASE_HI) ? base_q[63:32] :
		(sw_addr == prof_pkg::OFF_HEAD) ? head_q :
		(sw_addr == prof_pkg::OFF_DROP_LO) ? drop_q[31:0] :
		(sw_addr == prof_pkg::OFF_DROP_HI) ? drop_q[63:32] :
		(sw_addr == prof_pkg::OFF_THR) ? thr_q :
		(sw_addr == prof_pkg::OFF_FILT) ? filt_q :
		(sw_addr == prof_pkg::OFF_IPLO_LO) ? iplo_q[31:0] :
		(sw_addr == prof_pkg::OFF_IPLO_HI) ? iplo_q[63:32] :
		(sw_addr == prof_pkg::OFF_IPHI_LO) ? iphi_q[31:0] :
		(sw_addr == prof_pkg::OFF_IPHI_HI) ? iphi_q[63:32] :
		(sw_addr == prof_pkg::OFF_TAIL) ? tail_q :
		prof_pkg::RESET_WORD;

	////////////////////////////////////////////////////////////////////////
	// Software-written fields
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			size_q <= prof_pkg::RESET_WORD;
			base_q <= '0;
			thr_q <= prof_pkg::RESET_WORD;
			filt_q <= prof_pkg::RESET_WORD;
			iplo_q <= '0;
			iphi_q <= '0;
			tail_q <= prof_pkg::RESET_WORD;
			rdata_q <= prof_pkg::RESET_WORD;
		end else begin
			if (wr_size) size_q <= sw_wdata;
			if (wr_base_lo) base_q[31:0] <= sw_wdata;
			if (wr_base_hi) base_q[63:32] <= sw_wdata;
			if (wr_thr) thr_q <= sw_wdata;
			if (wr_filt) filt_q <= sw_wdata;
			if (wr_iplo_lo) iplo_q[31:0] <= sw_wdata;
			if (wr_iplo_hi) iplo_q[63:32] <= sw_wdata;
			if (wr_iphi_lo) iphi_q[31:0] <= sw_wdata;
			if (wr_iphi_hi) iphi_q[63:32] <= sw_wdata;
			// Only software changes the tail
			if (wr_tail) tail_q <= sw_wdata;
			// Live head and count readable at any time
			if (sw_rd) rdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Load, flags and linear base
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_q <= prof_pkg::RESET_WORD;
			lin_base_q <= '0;
			active_q <= 1'b0;
		end else begin
			if (load_req) begin
				flags_q <= flags_masked;
				lin_base_q <= lin_load;
				active_q <= 1'b1;
			end else begin
				if (wr_flags) flags_q <= sw_wdata;
				if (disable_req) active_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Head, dropped counter and threshold event
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			head_q <= prof_pkg::RESET_WORD;
			drop_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_q <= thr_hit;
			if (load_req) begin
				head_q <= head_san;
			end else if (store) begin
				if (ring_full) begin
					drop_q <= drop_q + 64'h1;
				end else begin
					head_q <= next_head;
				end
			end else if (wr_head) begin
				head_q <= sw_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Record buffering and counter reload
	rec_fifo #(
		.WIDTH(prof_pkg::DATA_W),
		.DEPTH(prof_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(rec_valid),
		.in_ready(rec_ready),
		.in_data(rec_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(mem_wr_data)
	);

	rand_reload u_rand (
		.sys_clk(sys_clk),
		.rst(rst),
		.reload_req(reload_req),
		.interval(reload_interval),
		.rand_bits(size_q[prof_pkg::RAND_LSB +: prof_pkg::RAND_W]),
		.reload_value(reload_value),
		.reload_done(reload_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	flags_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
		load_req |=> flags_q == ($past(flags_q) & $past(cap_bits)))
		else $error("flags not masked by capabilities");

	base_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		load_req && !wr_base_lo && !wr_base_hi |=>
		lin_base_q == $past(base_q) + $past(seg_base) &&
		base_q == $past(base_q))
		else $error("linear base wrong or base field changed");

	head_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		load_req && head_q >= size_eff |=> head_q == 32'h0)
		else $error("oversize head not replaced by zero");

	head_align_a: assert property (@(posedge sys_clk) disable iff (rst)
		active_q && $past(active_q) |-> head_q[prof_pkg::REC_SHIFT-1:0] == '0)
		else $error("head not record aligned while active");

	drop_count_a: assert property (@(posedge sys_clk) disable iff (rst)
		store && ring_full && !load_req |=>
		drop_q == $past(drop_q) + 64'h1 && head_q == $past(head_q))
		else $error("full ring did not count a dropped record");

	full_slot_a: assert property (@(posedge sys_clk) disable iff (rst)
		store && ring_full && !load_req |=>
		mem_wr_addr == $past(mem_wr_addr))
		else $error("full ring moved to a new slot");

	head_owned_a: assert property (@(posedge sys_clk) disable iff (rst)
		active_q && !store && !load_req |=> head_q == $past(head_q))
		else $error("head changed without a store");

	tail_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!wr_tail |=> $stable(tail_q))
		else $error("tail changed without software write");

	thr_event_a: assert property (@(posedge sys_clk) disable iff (rst)
		thr_irq |-> $past(store) && $past(flags_q[prof_pkg::THR_EN_BIT]) &&
		$past(used) >= $past(thr_eff))
		else $error("threshold event without cause");

	empty_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		store && !ring_full |=> !ring_empty || $past(load_req))
		else $error("ring reads empty after advance");

	head_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		store && !ring_full && !load_req |=>
		head_q == $past(next_head) && drop_q == $past(drop_q))
		else $error("advancing store moved head wrong or counted a drop");

	head_range_a: assert property (@(posedge sys_clk) disable iff (rst)
		active_q && size_eff != 32'h0 |-> head_q < size_eff)
		else $error("head outside the rounded ring while active");

	flags_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
		active_q && !load_req |=> $stable(flags_q))
		else $error("flags changed outside block load");

	thr_fire_a: assert property (@(posedge sys_clk) disable iff (rst)
		store && !ring_full && flags_q[prof_pkg::THR_EN_BIT] &&
		used >= thr_eff |=> thr_irq)
		else $error("threshold reached without an event");

	idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		!active_q |-> !mem_wr_valid)
		else $error("ring store offered while profiling is off");

	lin_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		active_q && !load_req |=> $stable(lin_base_q))
		else $error("linear base changed between block loads");
endmodule

// *** bench/mem_sink.sv ***
// Behavioural memory that takes the ring writer's record stores.
// Assumes the writer holds valid, address and data until ready is seen.
`timescale 1ns/10ps
module mem_sink (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hold,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [63:0] wr_addr,
	input wire logic [31:0] wr_data,
	output int n_stores
);
	logic slow_q;
	logic [63:0] addr_log [0:15];
	logic [31:0] data_log [0:15];
	////////////////////////////////////////////////////////////////////////
	// Ready only every other cycle, and never while held off
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slow_q <= 1'b0;
			wr_ready <= 1'b0;
			n_stores <= 0;
		end else begin
			slow_q <= ~slow_q;
			wr_ready <= ~hold & slow_q;
			if (wr_valid && wr_ready) begin
				addr_log[n_stores[3:0]] <= wr_addr;
				data_log[n_stores[3:0]] <= wr_data;
				n_stores <= n_stores + 1;
			end
		end
	end
endmodule

// *** bench/profiling_ring_control_block_test.sv ***
// Self-checking bench for the profiling control block and ring writer.
// Assumes the memory model in mem_sink and the map in prof_pkg.
`timescale 1ns/10ps
module profiling_ring_control_block_test;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sw_wr = 1'b0, sw_rd = 1'b0, load_req = 1'b0, disable_req = 1'b0;
	logic [6:0] sw_addr = 7'h00;
	logic [31:0] sw_wdata = 32'h0, cap_bits = 32'h8000_000f, rec_data = 32'h0;
	logic [63:0] seg_base = 64'h0001_0000;
	logic rec_valid = 1'b0, reload_req = 1'b0, hold = 1'b1;
	logic [24:0] reload_interval = 25'h1a5_a5a5;
	logic [31:0] sw_rdata, mem_wr_data;
	logic [63:0] mem_wr_addr;
	logic [24:0] reload_value;
	logic active, rec_ready, mem_wr_valid, mem_wr_ready;
	logic reload_done, ring_empty, thr_irq;
	int n_stores, miscompares = 0, n_checks = 0, irq_n = 0;
	// Smallest legal ring is 32 times this many records
	localparam int min_ring_records = 1;
	localparam logic [31:0] ring_req = 32 * min_ring_records *
		prof_pkg::REC_BYTES;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (thr_irq === 1'b1) irq_n++;
	prof_ring_ctrl u_prof_ring_ctrl (.sys_clk(sys_clk), .rst(rst),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_rdata(sw_rdata), .load_req(load_req), .disable_req(disable_req),
		.cap_bits(cap_bits), .seg_base(seg_base), .active(active),
		.rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
		.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.reload_req(reload_req), .reload_interval(reload_interval),
		.reload_value(reload_value), .reload_done(reload_done),
		.ring_empty(ring_empty), .thr_irq(thr_irq));
	mem_sink u_mem_sink (.sys_clk(sys_clk), .rst(rst), .hold(hold),
		.wr_valid(mem_wr_valid), .wr_ready(mem_wr_ready),
		.wr_addr(mem_wr_addr), .wr_data(mem_wr_data), .n_stores(n_stores));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		@(negedge sys_clk);
		chk($sformatf("reg %h", a), {32'h0, exp}, {32'h0, sw_rdata});
	endtask
	task automatic pulse(input int which);
		@(posedge sys_clk);
		if (which == 0) load_req <= 1'b1;
		else if (which == 1) disable_req <= 1'b1;
		else reload_req <= 1'b1;
		@(posedge sys_clk);
		load_req <= 1'b0;
		disable_req <= 1'b0;
		reload_req <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic push(input logic [31:0] d);
		@(posedge sys_clk);
		rec_valid <= 1'b1;
		rec_data <= d;
		do @(negedge sys_clk); while (rec_ready !== 1'b1);
		@(posedge sys_clk);
		rec_valid <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		miscompares++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(prof_pkg::OFF_HEAD, 32'h0);
		wr(prof_pkg::OFF_FLAGS, 32'h8000_00ff);
		wr(prof_pkg::OFF_SIZE, 32'h3000_0010 + ring_req);
		wr(prof_pkg::OFF_BASE_LO, 32'h0000_1000);
		wr(prof_pkg::OFF_BASE_HI, 32'h0);
		wr(prof_pkg::OFF_HEAD, 32'h3c8);
		wr(prof_pkg::OFF_THR, 32'h3d0);
		wr(prof_pkg::OFF_TAIL, 32'h3c0);
		// Eight records fill the FIFO while profiling is still off
		for (int k = 0; k < 8; k++) push(32'ha00 + k);
		@(negedge sys_clk);
		chk("rec_ready", 64'h0, {63'h0, rec_ready});
		chk("mem_wr_valid", 64'h0, {63'h0, mem_wr_valid});
		pulse(0);
		chk("active", 64'h1, {63'h0, active});
		rd(prof_pkg::OFF_FLAGS, 32'h8000_000f);
		rd(prof_pkg::OFF_BASE_LO, 32'h0000_1000);
		rd(prof_pkg::OFF_HEAD, 32'h3c0);
		chk("ring_empty", 64'h1, {63'h0, ring_empty});
		wr(prof_pkg::OFF_TAIL, 32'h40);
		hold <= 1'b0;
		push(32'ha08);
		for (int j = 0; j < 300 && n_stores != 9; j++) @(posedge sys_clk);
		chk("stores", 64'd9, 64'(n_stores));
		// Slots 3c0 and 3e0, wrap at the rounded size to 0, then stick at 20
		for (int k = 0; k < 9; k++) begin
			chk("addr", 64'h11000 +
				((32'h3c0 + 32'h20 * (k < 3 ? k : 3)) & 32'h3ff),
				u_mem_sink.addr_log[k]);
			chk("data", 64'ha00 + k, {32'h0, u_mem_sink.data_log[k]});
		end
		rd(prof_pkg::OFF_HEAD, 32'h20);
		rd(prof_pkg::OFF_DROP_LO, 32'h6);
		rd(prof_pkg::OFF_DROP_HI, 32'h0);
		rd(prof_pkg::OFF_TAIL, 32'h40);
		chk("irq pulses", 64'd2, 64'(irq_n));
		chk("ring_empty", 64'h0, {63'h0, ring_empty});
		wr(prof_pkg::OFF_HEAD, 32'h0);
		rd(prof_pkg::OFF_HEAD, 32'h20);
		wr(prof_pkg::OFF_DROP_LO, 32'h0);
		rd(prof_pkg::OFF_DROP_LO, 32'h6);
		wr(prof_pkg::OFF_FLAGS, 32'h0);
		rd(prof_pkg::OFF_FLAGS, 32'h8000_000f);
		rd(7'h3c, 32'h0);
		pulse(2);
		chk("reload_done", 64'h1, {63'h0, reload_done});
		chk("reload_hi", 64'(reload_interval[24:3]),
			64'(reload_value[24:3]));
		pulse(1);
		chk("active", 64'h0, {63'h0, active});
		wr(prof_pkg::OFF_FLAGS, 32'h1);
		rd(prof_pkg::OFF_FLAGS, 32'h1);
		wr(prof_pkg::OFF_HEAD, 32'h400);
		pulse(0);
		rd(prof_pkg::OFF_HEAD, 32'h0);
		end_of_test;
	end
endmodule
